// *** shared/amc_pkg.sv ***
// Constants, field layouts and types for the converter mode configuration port.
//
// Notes on behaviour
// - With the scheme strap low the four configuration pins form a serial port that writes the mode registers.
// - With the scheme strap high the four pins are static levels that set a reduced set of modes.
// - Serial bits are shifted only while chip select is low, and the controller holds it low for a whole frame.
// - Each serial input bit is captured on the rising edge of the serial clock.
// - Read-back bits of a mode register leave on the data output after the falling serial clock edge.
// - The data output is open-drain, only pulling low or releasing, and may be left unused.
// - In the static scheme the chip select level picks two lanes or one lane per channel.
// - In the static scheme the serial clock level picks the high or low output drive current.
// - In the static scheme the serial input level powers the converter down when high.
// - In the static scheme the data output pin is an input whose level enables output termination.
// - A conversion starts on the rising edge of the true encode input, the falling edge of its complement.
// - With two lanes and 14-bit serialization the frame start output toggles once per encode period.
// - In every one-lane mode the second lane of each channel is disabled.
`default_nettype none
package amc_pkg;
  // ************************************************************
  // Register bus
  // ************************************************************
  localparam int AMC_AW = 5;
  localparam int AMC_DW = 32;
  localparam logic [4:0] AMC_OFS_STATUS = 5'h00;
  localparam logic [4:0] AMC_OFS_MODE0 = 5'h04;
  localparam logic [4:0] AMC_OFS_MODE1 = 5'h08;
  localparam logic [4:0] AMC_OFS_CTRL = 5'h0c;
  localparam logic [4:0] AMC_OFS_CONVCNT = 5'h10;
  localparam int AMC_CTRL_LOCK_BIT = 0;
  localparam logic [31:0] AMC_CTRL_RST = 32'h0000_0000;
  // ************************************************************
  // Serial frame and mode registers
  // ************************************************************
  localparam logic [4:0] AMC_FRAME_LAST = 5'h0f;
  localparam logic [4:0] AMC_ADDR_LAST = 5'h07;
  localparam logic [4:0] AMC_FRAME_DONE = 5'h10;
  localparam logic [6:0] AMC_MODE_PWR = 7'h00;
  localparam logic [6:0] AMC_MODE_OUT = 7'h01;
  localparam logic [7:0] AMC_MODE_RST = 8'h00;
  localparam int AMC_PWR_DOWN_BIT = 0;
  localparam int AMC_OUT_ONE_LANE_BIT = 0;
  localparam int AMC_OUT_SER_LSB = 1;
  localparam int AMC_OUT_CUR_LOW_BIT = 3;
  localparam int AMC_OUT_TERM_BIT = 4;
  localparam logic [1:0] AMC_SER_16 = 2'b00;
  localparam logic [1:0] AMC_SER_14 = 2'b01;
  localparam logic [1:0] AMC_SER_12 = 2'b10;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int AMC_CLK_PERIOD_NS = 8;
  localparam int AMC_TSER_MIN_NS = 1;
  typedef enum logic [1:0] {
    AMC_BUS_IDLE = 2'b01,
    AMC_BUS_ACK = 2'b10
  } amc_bus_state_t;
endpackage
`default_nettype wire

// *** hdl/amc_config_port.sv ***
// Mode configuration port: serial or static pin scheme, encode edge and lane framing.
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module amc_config_port (
  // System clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Avalon-MM slave
  input wire logic [amc_pkg::AMC_AW-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [amc_pkg::AMC_DW-1:0] writedata_i,
  output logic [amc_pkg::AMC_DW-1:0] readdata_o,
  output logic waitrequest_o,
  // Configuration pins
  input wire logic program_scheme_strap_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic sdo_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Encode inputs
  input wire logic encode_clock_true_i,
  input wire logic encode_clock_comp_i,
  // Mode outputs
  output logic two_lane_o,
  output logic lane_b_enable_o,
  output logic drive_high_o,
  output logic power_down_o,
  output logic termination_en_o,
  output logic [1:0] serialization_o,
  output logic conv_start_o,
  output logic frame_start_out_o
);
  import amc_pkg::*;

  // ************************************************************
  // Reset release and pin synchronisers
  // ************************************************************
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [6:0] pin_s1_reg;
  logic [6:0] pin_s2_reg;
  wire strap_s = pin_s2_reg[0];
  wire cs_n_s = pin_s2_reg[1];
  wire sck_s = pin_s2_reg[2];
  wire sdi_s = pin_s2_reg[3];
  wire sdo_s = pin_s2_reg[4];
  wire enc_t_s = pin_s2_reg[5];
  wire enc_c_s = pin_s2_reg[6];

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 7'h02;
      pin_s2_reg <= 7'h02;
    end
    else
    begin
      pin_s1_reg <= {encode_clock_comp_i, encode_clock_true_i, sdo_i, sdi_i, sck_i, cs_n_i,
                     program_scheme_strap_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ************************************************************
  // Serial link on the serial clock
  // ************************************************************
  logic [4:0] bit_cnt_reg;
  logic [14:0] shift_reg;
  logic rd_frame_reg;
  logic [6:0] addr_reg;
  logic [14:0] hold_word_reg;
  logic wr_tog_reg;
  logic [7:0] shadow_reg [0:1];
  logic sdo_bit_reg;
  wire frame_clr = ~rst_n | cs_n_i | program_scheme_strap_i;
  wire [15:0] word_in = {shift_reg, sdi_i};
  wire frame_end = (bit_cnt_reg == AMC_FRAME_LAST);
  wire wr_end = frame_end & ~shift_reg[14];
  wire [7:0] rd_byte = (addr_reg == AMC_MODE_OUT) ? shadow_reg[1] :
                       (addr_reg == AMC_MODE_PWR) ? shadow_reg[0] : 8'h00;
  wire rd_phase = rd_frame_reg & (bit_cnt_reg > AMC_ADDR_LAST) & (bit_cnt_reg < AMC_FRAME_DONE);
  wire [2:0] rd_idx = 3'(AMC_FRAME_LAST - bit_cnt_reg);

  always_ff @(posedge sck_i or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= 15'h0000;
      rd_frame_reg <= 1'b0;
      addr_reg <= 7'h00;
    end
    else if (bit_cnt_reg != AMC_FRAME_DONE)
    begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      shift_reg <= word_in[14:0];
      if (bit_cnt_reg == AMC_ADDR_LAST)
      begin
        rd_frame_reg <= shift_reg[6];
        addr_reg <= {shift_reg[5:0], sdi_i};
      end
    end
  end

  always_ff @(posedge sck_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_word_reg <= 15'h0000;
      wr_tog_reg <= 1'b0;
      shadow_reg[0] <= AMC_MODE_RST;
      shadow_reg[1] <= AMC_MODE_RST;
    end
    else if (wr_end && !cs_n_i && !program_scheme_strap_i)
    begin
      hold_word_reg <= word_in[14:0];
      wr_tog_reg <= ~wr_tog_reg;
      if (word_in[14:8] == AMC_MODE_PWR)
        shadow_reg[0] <= word_in[7:0];
      if (word_in[14:8] == AMC_MODE_OUT)
        shadow_reg[1] <= word_in[7:0];
    end
  end

  always_ff @(negedge sck_i or posedge frame_clr)
  begin
    if (frame_clr)
      sdo_bit_reg <= 1'b1;
    else if (rd_phase)
      sdo_bit_reg <= rd_byte[rd_idx];
    else
      sdo_bit_reg <= 1'b1;
  end
  assign sdo_o = 1'b0;
  assign sdo_oe_o = ~sdo_bit_reg;

  // ************************************************************
  // Write crossing into the system clock
  // ************************************************************
  logic [2:0] tog_sync_reg;
  logic [7:0] mode_reg [0:1];
  logic [31:0] ctrl_reg;
  wire wr_seen = tog_sync_reg[2] ^ tog_sync_reg[1];
  wire spi_lock = ctrl_reg[AMC_CTRL_LOCK_BIT];
  wire spi_apply = wr_seen & ~spi_lock & ~strap_s;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      tog_sync_reg <= 3'b000;
    else
      tog_sync_reg <= {tog_sync_reg[1:0], wr_tog_reg};
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg[0] <= AMC_MODE_RST;
      mode_reg[1] <= AMC_MODE_RST;
    end
    else if (spi_apply)
    begin
      if (hold_word_reg[14:8] == AMC_MODE_PWR)
        mode_reg[0] <= hold_word_reg[7:0];
      if (hold_word_reg[14:8] == AMC_MODE_OUT)
        mode_reg[1] <= hold_word_reg[7:0];
    end
  end

  // ************************************************************
  // Mode selection from registers or static pins
  // ************************************************************
  wire ser_two = ~mode_reg[1][AMC_OUT_ONE_LANE_BIT];
  wire two_next = strap_s ? cs_n_s : ser_two;
  wire drive_next = strap_s ? sck_s : ~mode_reg[1][AMC_OUT_CUR_LOW_BIT];
  wire pd_next = strap_s ? sdi_s : mode_reg[0][AMC_PWR_DOWN_BIT];
  wire term_next = strap_s ? sdo_s : mode_reg[1][AMC_OUT_TERM_BIT];
  wire [1:0] ser_next = strap_s ? AMC_SER_16 : mode_reg[1][AMC_OUT_SER_LSB +: 2];
  wire enc_level = enc_t_s & ~enc_c_s;
  logic enc_prev_reg;
  wire conv_next = enc_level & ~enc_prev_reg;
  wire frame_tog_mode = two_lane_o & (serialization_o == AMC_SER_14);
  wire frame_next = frame_tog_mode ? (frame_start_out_o ^ conv_next) : enc_level;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      two_lane_o <= 1'b1;
      lane_b_enable_o <= 1'b1;
      drive_high_o <= 1'b1;
      power_down_o <= 1'b0;
      termination_en_o <= 1'b0;
      serialization_o <= AMC_SER_16;
      enc_prev_reg <= 1'b0;
      conv_start_o <= 1'b0;
      frame_start_out_o <= 1'b0;
    end
    else
    begin
      two_lane_o <= two_next;
      lane_b_enable_o <= two_next;
      drive_high_o <= drive_next;
      power_down_o <= pd_next;
      termination_en_o <= term_next;
      serialization_o <= ser_next;
      enc_prev_reg <= enc_level;
      conv_start_o <= conv_next;
      frame_start_out_o <= frame_next;
    end
  end

  // ************************************************************
  // Conversion counter
  // ************************************************************
  logic [31:0] conv_cnt_reg;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      conv_cnt_reg <= 32'h0000_0000;
    else if (conv_next)
      conv_cnt_reg <= conv_cnt_reg + 32'h0000_0001;
  end

  // ************************************************************
  // Avalon-MM slave
  // ************************************************************
  amc_bus_state_t bus_state_reg;
  amc_bus_state_t bus_state_next;
  logic [31:0] rdata_reg;
  wire req = read_i | write_i;
  wire hit_status = (address_i == AMC_OFS_STATUS);
  wire hit_mode0 = (address_i == AMC_OFS_MODE0);
  wire hit_mode1 = (address_i == AMC_OFS_MODE1);
  wire hit_ctrl = (address_i == AMC_OFS_CTRL);
  wire hit_cnt = (address_i == AMC_OFS_CONVCNT);
  wire [31:0] status_word = {26'h0, power_down_o, termination_en_o, drive_high_o, two_lane_o,
                             cs_n_s, strap_s};
  wire [31:0] rd_mux = hit_status ? status_word :
                       hit_mode0 ? {24'h0, mode_reg[0]} :
                       hit_mode1 ? {24'h0, mode_reg[1]} :
                       hit_ctrl ? ctrl_reg :
                       hit_cnt ? conv_cnt_reg : 32'h0000_0000;
  wire bus_ack = (bus_state_reg == AMC_BUS_ACK);
  wire ctrl_we = bus_ack & write_i & hit_ctrl;

  always_comb
  begin
    case (bus_state_reg)
      AMC_BUS_IDLE: bus_state_next = req ? AMC_BUS_ACK : AMC_BUS_IDLE;
      AMC_BUS_ACK: bus_state_next = AMC_BUS_IDLE;
      default: bus_state_next = AMC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_state_reg <= AMC_BUS_IDLE;
      rdata_reg <= 32'h0000_0000;
      ctrl_reg <= AMC_CTRL_RST;
    end
    else
    begin
      bus_state_reg <= bus_state_next;
      if (!bus_ack && read_i)
        rdata_reg <= rd_mux;
      if (ctrl_we && byteenable_i[0])
        ctrl_reg[7:0] <= writedata_i[7:0];
      if (ctrl_we && byteenable_i[1])
        ctrl_reg[15:8] <= writedata_i[15:8];
      if (ctrl_we && byteenable_i[2])
        ctrl_reg[23:16] <= writedata_i[23:16];
      if (ctrl_we && byteenable_i[3])
        ctrl_reg[31:24] <= writedata_i[31:24];
    end
  end
  assign waitrequest_o = req & ~bus_ack;
  assign readdata_o = rdata_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  AST_SER_APPLY: assert property (@(posedge clk_i) disable iff (!rst_n)
    (spi_apply && hold_word_reg[14:8] == AMC_MODE_OUT) |=> (mode_reg[1] == $past(hold_word_reg[7:0])))
    else $error("Serial write not applied to output mode register");
  AST_PAR_PD: assert property (@(posedge clk_i) disable iff (!rst_n)
    (strap_s && sdi_s) ##1 strap_s |-> power_down_o)
    else $error("Static power-down pin not followed");
  AST_CS_HOLD: assert property (@(posedge sck_i) disable iff (!rst_n)
    cs_n_i |=> (wr_tog_reg == $past(wr_tog_reg)))
    else $error("Write took effect with chip select high");
  AST_SHIFT_IN: assert property (@(posedge sck_i) disable iff (frame_clr)
    (bit_cnt_reg < AMC_FRAME_LAST) |=> (shift_reg[0] == $past(sdi_i)))
    else $error("Serial input bit not captured on rising edge");
  AST_RD_BIT: assert property (@(negedge sck_i) disable iff (frame_clr)
    rd_phase |=> (sdo_bit_reg == $past(rd_byte[rd_idx])))
    else $error("Read-back bit wrong on serial output");
  AST_OD: assert property (@(posedge clk_i) disable iff (!rst_n)
    !sdo_o && (!sdo_oe_o || (rd_frame_reg && !cs_n_i)))
    else $error("Serial output drove high");
  AST_PAR_LANE: assert property (@(posedge clk_i) disable iff (!rst_n)
    (strap_s && $stable(cs_n_s)) ##1 strap_s |-> (two_lane_o == $past(cs_n_s)))
    else $error("Static lane select not followed");
  AST_PAR_CUR: assert property (@(posedge clk_i) disable iff (!rst_n)
    strap_s ##1 strap_s |-> (drive_high_o == $past(sck_s)))
    else $error("Static drive current select not followed");
  AST_PAR_TERM: assert property (@(posedge clk_i) disable iff (!rst_n)
    strap_s ##1 strap_s |-> (termination_en_o == $past(sdo_s)))
    else $error("Static termination select not followed");
  AST_CONV: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(enc_level) |=> conv_start_o ##1 !conv_start_o)
    else $error("Conversion start not a single pulse on encode rise");
  AST_FRAME_TOG: assert property (@(posedge clk_i) disable iff (!rst_n)
    (frame_tog_mode && conv_next) |=> (frame_start_out_o != $past(frame_start_out_o)))
    else $error("Frame start did not toggle on conversion");
  AST_LANE_B: assert property (@(posedge clk_i) disable iff (!rst_n)
    !two_lane_o |-> !lane_b_enable_o)
    else $error("Second lane enabled in one-lane mode");
  AST_CS_IDLE: assert property (@(posedge sck_i) disable iff (!rst_n)
    cs_n_i |-> (bit_cnt_reg == 5'h00))
    else $error("Serial frame advanced while chip select high");
endmodule
`default_nettype wire

// *** test/amc_spi_ctrl.sv ***
// Behavioural serial configuration controller facing the mode configuration port.
`timescale 1ns/10ps
`default_nettype none
module amc_spi_ctrl (
  // Serial pins
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o,
  input wire logic sdo_wire_i
);
  localparam int HALF = 32;
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // ************************************************************
  // One 16-bit frame, first bit read or write, read bits taken on falling edges.
  // ************************************************************
  task automatic frame(input logic rd, input logic [6:0] adr, input logic [7:0] dat,
                       output logic [7:0] got);
    logic [15:0] word;
    word = {rd, adr, dat};
    got = 8'h00;
    #3;
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdi_o = word[i];
      #(HALF);
      sck_o = 1'b1;
      #(HALF);
      if (i < 8)
      begin
        got[i] = sdo_wire_i;
      end
      sck_o = 1'b0;
    end
    #(HALF);
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask
  // ************************************************************
  // Stray clock and data edges while deselected, ordered by a scenario.
  // ************************************************************
  task automatic stray(input int n);
    for (int i = 0; i < n; i++)
    begin
      sdi_o = ~sdi_o;
      #(HALF);
      sck_o = ~sck_o;
      #(HALF);
    end
    sck_o = 1'b0;
  endtask
  // Static levels for the pin scheme.
  task automatic set_pins(input logic cs, input logic ck, input logic di);
    cs_n_o <= cs;
    sck_o <= ck;
    sdi_o <= di;
  endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the mode configuration port.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import amc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [4:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata;
  logic waitrequest;
  logic strap = 1'b0;
  logic term_lvl = 1'b0;
  logic enc_t = 1'b0;
  logic enc_c = 1'b1;
  logic cs_n, sck, sdi, sdo_o, sdo_oe, sdo_wire, sdo_in;
  logic two_lane, lane_b, drive_high, power_down, term_en, conv_start, frame_out;
  logic [1:0] ser;
  int err_count = 0;
  int total_checks = 0;
  logic [31:0] q;
  logic [7:0] sb;
  assign sdo_wire = sdo_oe ? sdo_o : 1'b1;
  assign sdo_in = strap ? term_lvl : sdo_wire;
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  amc_spi_ctrl ctrl (.cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi), .sdo_wire_i(sdo_wire));
  amc_config_port uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .address_i(address),
    .read_i(read), .write_i(write), .byteenable_i(4'hf), .writedata_i(writedata),
    .readdata_o(readdata), .waitrequest_o(waitrequest), .program_scheme_strap_i(strap),
    .cs_n_i(cs_n), .sck_i(sck), .sdi_i(sdi), .sdo_i(sdo_in), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe), .encode_clock_true_i(enc_t), .encode_clock_comp_i(enc_c),
    .two_lane_o(two_lane), .lane_b_enable_o(lane_b), .drive_high_o(drive_high),
    .power_down_o(power_down), .termination_en_o(term_en), .serialization_o(ser),
    .conv_start_o(conv_start), .frame_start_out_o(frame_out));
  // ************************************************************
  // Compare, bus and reporting tasks
  // ************************************************************
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %b seen %b", what, exp, got);
      err_count++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd,
                     output logic [31:0] rq);
    logic ws;
    int n;
    ws = 1'b1;
    n = 0;
    rq = '0;
    @(posedge clk_i);
    address <= adr;
    write <= wr;
    read <= !wr;
    writedata <= wd;
    while (ws !== 1'b0 && n < 20)
    begin
      @(posedge clk_i);
      ws = waitrequest;
      rq = readdata;
      n++;
    end
    read <= 1'b0;
    write <= 1'b0;
    if (ws !== 1'b0)
    begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    strap <= s;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset_vals();
    bus(1'b0, AMC_OFS_CTRL, '0, q);
    chk_word("ctrl", AMC_CTRL_RST, q);
    bus(1'b0, AMC_OFS_MODE1, '0, q);
    chk_word("mode1", 32'h0, q);
    bus(1'b0, 5'h14, '0, q);
    chk_word("unmapped", 32'h0, q);
    bus(1'b0, AMC_OFS_STATUS, '0, q);
    chk_word("status", 32'h0e, q);
    $display("test reset_vals done");
  endtask
  task automatic t_serial_write();
    ctrl.frame(1'b0, AMC_MODE_OUT, 8'h1b, sb);
    ctrl.frame(1'b0, AMC_MODE_PWR, 8'h01, sb);
    repeat (8) @(posedge clk_i);
    chk_bit("two_lane", 1'b0, two_lane);
    chk_bit("lane_b", 1'b0, lane_b);
    chk_bit("drive_high", 1'b0, drive_high);
    chk_bit("term", 1'b1, term_en);
    chk_word("ser", 32'(AMC_SER_14), 32'(ser));
    chk_bit("power_down", 1'b1, power_down);
    bus(1'b0, AMC_OFS_STATUS, '0, q);
    chk_word("status", 32'h32, q);
    ctrl.frame(1'b0, AMC_MODE_PWR, 8'h00, sb);
    repeat (8) @(posedge clk_i);
    chk_bit("power_up", 1'b0, power_down);
    $display("test serial_write done");
  endtask
  task automatic t_readback();
    ctrl.frame(1'b1, AMC_MODE_OUT, 8'h00, sb);
    chk_word("readback", 32'h1b, 32'(sb));
    ctrl.frame(1'b1, 7'h05, 8'h00, sb);
    chk_word("readback_unmapped", 32'h00, 32'(sb));
    #40;
    chk_bit("sdo_released", 1'b0, sdo_oe);
    chk_bit("sdo_low_only", 1'b0, sdo_o);
    $display("test readback done");
  endtask
  task automatic t_deselected();
    ctrl.stray(20);
    repeat (8) @(posedge clk_i);
    bus(1'b0, AMC_OFS_MODE1, '0, q);
    chk_word("mode1_kept", 32'h1b, q);
    ctrl.frame(1'b1, AMC_MODE_OUT, 8'h00, sb);
    chk_word("shadow_kept", 32'h1b, 32'(sb));
    $display("test deselected done");
  endtask
  task automatic t_lock();
    bus(1'b1, AMC_OFS_CTRL, 32'h1, q);
    bus(1'b0, AMC_OFS_CTRL, '0, q);
    chk_word("ctrl_lock", 32'h1, q);
    ctrl.frame(1'b0, AMC_MODE_OUT, 8'h00, sb);
    repeat (8) @(posedge clk_i);
    chk_bit("locked_two_lane", 1'b0, two_lane);
    ctrl.frame(1'b1, AMC_MODE_OUT, 8'h00, sb);
    chk_word("locked_shadow", 32'h00, 32'(sb));
    bus(1'b1, AMC_OFS_CTRL, 32'h0, q);
    ctrl.frame(1'b0, AMC_MODE_OUT, 8'h02, sb);
    repeat (8) @(posedge clk_i);
    chk_bit("two_lane_on", 1'b1, two_lane);
    chk_bit("lane_b_on", 1'b1, lane_b);
    $display("test lock done");
  endtask
  task automatic t_encode();
    logic prev;
    int cnt;
    logic [31:0] base;
    bus(1'b0, AMC_OFS_CONVCNT, '0, base);
    prev = frame_out;
    // A 20-cycle encode period keeps each 14-bit lane bit well above 1 ns.
    for (int k = 0; k < 4; k++)
    begin
      cnt = 0;
      @(posedge clk_i);
      enc_t <= 1'b1;
      enc_c <= 1'b0;
      repeat (10) @(negedge clk_i) cnt += int'(conv_start === 1'b1);
      chk_word("starts_on_rise", 32'h1, 32'(cnt));
      chk_bit("frame_toggle", ~prev, frame_out);
      prev = frame_out;
      cnt = 0;
      @(posedge clk_i);
      enc_t <= 1'b0;
      enc_c <= 1'b1;
      repeat (10) @(negedge clk_i) cnt += int'(conv_start === 1'b1);
      chk_word("none_on_fall", 32'h0, 32'(cnt));
    end
    bus(1'b0, AMC_OFS_CONVCNT, '0, q);
    chk_word("conv_count", base + 32'h4, q);
    ctrl.frame(1'b0, AMC_MODE_OUT, 8'h04, sb);
    repeat (8) @(posedge clk_i);
    chk_word("ser12", 32'(AMC_SER_12), 32'(ser));
    enc_t <= 1'b1;
    enc_c <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk_bit("frame_level_hi", 1'b1, frame_out);
    enc_t <= 1'b0;
    enc_c <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk_bit("frame_level_lo", 1'b0, frame_out);
    $display("test encode done");
  endtask
  task automatic t_static();
    do_reset(1'b1);
    ctrl.set_pins(1'b1, 1'b0, 1'b1);
    term_lvl <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk_bit("st_two_lane", 1'b1, two_lane);
    chk_bit("st_drive", 1'b0, drive_high);
    chk_bit("st_pd", 1'b1, power_down);
    chk_bit("st_term", 1'b1, term_en);
    chk_word("st_ser", 32'(AMC_SER_16), 32'(ser));
    bus(1'b0, AMC_OFS_STATUS, '0, q);
    chk_word("st_status", 32'h37, q);
    ctrl.set_pins(1'b0, 1'b1, 1'b0);
    term_lvl <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk_bit("st_one_lane", 1'b0, two_lane);
    chk_bit("st_lane_b", 1'b0, lane_b);
    chk_bit("st_drive_hi", 1'b1, drive_high);
    chk_bit("st_pd_off", 1'b0, power_down);
    chk_bit("st_term_off", 1'b0, term_en);
    $display("test static done");
  endtask
  initial
  begin
    #500000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    do_reset(1'b0);
    t_reset_vals();
    t_serial_write();
    t_readback();
    t_deselected();
    t_lock();
    t_encode();
    t_static();
    report_and_stop();
  end
endmodule
`default_nettype wire
